// ### src/tmr_defines.vh
// Purpose: Constants for the timer configuration and counter control block
// Assumes: One clock at 125 MHz; Avalon-MM word addressing
// Notes: Offsets are word addresses of 32-bit registers
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// Register word offsets
`define OFS_CONTROL     4'h0
`define OFS_CONFIG      4'h1
`define OFS_COUNT       4'h2
`define OFS_MODULO      4'h3
`define ADDR_W          4

// Control register fields
`define CTL_CLK_LO      0
`define CTL_CLK_HI      1
// Configuration register fields
`define CFG_DOZE        5
`define CFG_DBG_LO      6
`define CFG_DBG_HI      7
`define CFG_SHARED      9
`define CFG_BEGIN_TRIG  16
`define CFG_HALT_WRAP   17
`define CFG_WMASK       32'h0003_02E0

// Status / mask offsets and bits
`define OFS_STATUS      4'h4
`define OFS_MASK        4'h5
`define ST_OVERFLOW     0
`define ST_TRIGGER      1
`define ST_W            2

// Field codes
`define DBG_RUN         2'h3
`define CLK_OFF         2'h0

// Reset values
`define RST_CONFIG      32'h0000_0000
`define RST_MODULO      16'hFFFF
// Trigger synchroniser depth before the edge detector
`define TRIG_SYNC_STAGES 2

`endif

// ### src/trig_edge_sync.v
// Purpose: Synchronise the trigger input and detect its rising edge
// Assumes: Trigger from other logic, may be asynchronous
// Notes: Edge pulse appears three clocks after trigger rises
`timescale 1ns/10ps
`include "tmr_defines.vh"

module trig_edge_sync (
  // Clock and reset
  input  wire clock,
  input  wire rst_n,
  // Trigger in, edge out
  input  wire trig_in,
  output reg  trig_rise
);

  reg [`TRIG_SYNC_STAGES-1:0] sync;
  reg                         last;

  // Two-stage synchroniser, then edge detect on the last stage
  always @(posedge clock) begin
    if (!rst_n) begin
      sync      <= {`TRIG_SYNC_STAGES{1'b0}};
      last      <= 1'b0;
      trig_rise <= 1'b0;
    end else begin
      sync      <= {sync[`TRIG_SYNC_STAGES-2:0], trig_in};
      last      <= sync[`TRIG_SYNC_STAGES-1];
      trig_rise <= sync[`TRIG_SYNC_STAGES-1] & ~last;
    end
  end

endmodule // trig_edge_sync

// ### src/count_core.v
// Purpose: 16-bit up counter with modulo wrap and overflow pulse
// Assumes: Run and clear decided by the control logic
// Notes: Modulo zero wraps every counting clock
`timescale 1ns/10ps

module count_core (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Control
  input  wire        run,
  input  wire        clear,
  input  wire [15:0] modulo_value,
  // Results
  output reg  [15:0] count,
  output reg         wrap
);

  // Count, wrap at modulo and flag the wrap for one clock
  always @(posedge clock) begin
    if (!rst_n) begin
      count <= 16'h0000;
      wrap  <= 1'b0;
    end else if (clear) begin
      count <= 16'h0000;
      wrap  <= 1'b0;
    end else if (run) begin
      if (count == modulo_value) begin
        count <= 16'h0000;
        wrap  <= 1'b1;
      end else begin
        count <= count + 16'h0001;
        wrap  <= 1'b0;
      end
    end else begin
      wrap <= 1'b0;
    end
  end

endmodule // count_core

// ### src/timer_counter_config_control.v
// Purpose: Timer configuration, start/stop control and register slave
// Assumes: Avalon-MM slave, one clock, inputs synchronous except trigger
// Notes: Channels read the selected timebase on timebase_count
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "tmr_defines.vh"

module timer_counter_config_control (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire [4:0]  avs_address_hi,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  // Mode and trigger inputs
  input  wire        debug_mode,
  input  wire        doze_mode,
  input  wire        trigger_in,
  // Shared timebase from the generating timer
  input  wire [15:0] shared_count,
  input  wire        shared_enable,
  input  wire        shared_wrap,
  // Timebase to channels and own state
  output reg  [15:0] timebase_count,
  output reg         timebase_enable,
  output reg         timebase_wrap,
  output reg  [15:0] local_count,
  output reg         irq
);

  // Register state
  reg  [1:0]  counter_clock_select;
  reg         halt_after_wrap;
  reg         begin_on_trigger_edge;
  reg         shared_timebase_select;
  reg  [1:0]  debug_behaviour_field;
  reg         doze_pause_select;
  reg  [15:0] modulo_value;
  reg  [`ST_W-1:0] status;
  reg  [`ST_W-1:0] mask;
  // Counter control state
  reg         halted;
  reg         waiting;
  reg         was_enabled;
  reg         cnt_clear;
  // Bus control
  reg         busy;
  wire        enabled;
  wire        paused;
  wire        counting;
  wire        trig_rise;
  wire        trig_seen;
  wire [15:0] count;
  wire        wrap;
  wire        access;
  wire [31:0] be_mask;
  wire [31:0] wdata;
  wire        rd_status;
  reg  [31:0] next_readdata;
  reg  [1:0]  next_response;

  // Byte-enable expansion, used on every writable register except the count clear
  function [31:0] lanes;
    input [3:0] be;
    begin
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Address decode test, used by read and write paths
  function hit;
    input [3:0] adr;
    input [4:0] hi;
    input [3:0] ofs;
    begin
      hit = (hi == 5'h00) && (adr == ofs);
    end
  endfunction

  assign be_mask = lanes(avs_byteenable);
  assign wdata   = avs_writedata & be_mask;

  // Counter enabled by a nonzero clock select
  assign enabled = (counter_clock_select != `CLK_OFF);
  // Pause in debug unless running code, pause in doze when selected
  assign paused  = (debug_mode && (debug_behaviour_field != `DBG_RUN)) ||
                   (doze_mode && doze_pause_select);
  // Trigger edges dropped while paused
  assign trig_seen = trig_rise & ~paused;
  // Stop on the wrap edge itself so a halted count rests at zero
  assign counting  = enabled && !paused && !halted && !waiting &&
                     !(wrap && halt_after_wrap);

  trig_edge_sync i_trig_edge_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .trig_in   (trigger_in),
    .trig_rise (trig_rise)
  );

  count_core i_count_core (
    .clock        (clock),
    .rst_n        (rst_n),
    .run          (counting),
    .clear        (cnt_clear),
    .modulo_value (modulo_value),
    .count        (count),
    .wrap         (wrap)
  );

  // Start, halt and trigger restart control
  always @(posedge clock) begin
    if (!rst_n) begin
      halted      <= 1'b0;
      waiting     <= 1'b0;
      was_enabled <= 1'b0;
    end else begin
      was_enabled <= enabled;
      if (!enabled) begin
        // Disable clears halt and arms the trigger wait before enable
        halted  <= 1'b0;
        waiting <= begin_on_trigger_edge;
      end else if (!was_enabled) begin
        waiting <= begin_on_trigger_edge;
        halted  <= 1'b0;
      end else if (begin_on_trigger_edge && trig_seen) begin
        waiting <= 1'b0;
        halted  <= 1'b0;
      end else if (wrap && halt_after_wrap) begin
        halted <= 1'b1;
      end
    end
  end

  // Channel timebase selection and local count output
  always @(posedge clock) begin
    if (!rst_n) begin
      timebase_count  <= 16'h0000;
      timebase_enable <= 1'b0;
      timebase_wrap   <= 1'b0;
      local_count     <= 16'h0000;
    end else begin
      local_count <= count;
      if (shared_timebase_select) begin
        timebase_count  <= shared_count;
        timebase_enable <= shared_enable;
        timebase_wrap   <= shared_wrap;
      end else begin
        timebase_count  <= count;
        timebase_enable <= counting;
        timebase_wrap   <= wrap;
      end
    end
  end

  // Waitrequest drops one clock after request; the access is taken at the next edge
  assign access    = (avs_read || avs_write) && busy;
  assign rd_status = avs_read && hit(avs_address, avs_address_hi, `OFS_STATUS);

  // Read mux; reserved bits and unmapped addresses read zero
  always @* begin
    next_readdata = 32'h0000_0000;
    next_response = 2'h0;
    if (hit(avs_address, avs_address_hi, `OFS_CONTROL)) begin
      next_readdata[`CTL_CLK_HI:`CTL_CLK_LO] = counter_clock_select;
    end else if (hit(avs_address, avs_address_hi, `OFS_CONFIG)) begin
      next_readdata[`CFG_HALT_WRAP]  = halt_after_wrap;
      next_readdata[`CFG_BEGIN_TRIG] = begin_on_trigger_edge;
      next_readdata[`CFG_SHARED]     = shared_timebase_select;
      next_readdata[`CFG_DBG_HI:`CFG_DBG_LO] = debug_behaviour_field;
      next_readdata[`CFG_DOZE]       = doze_pause_select;
    end else if (hit(avs_address, avs_address_hi, `OFS_COUNT)) begin
      next_readdata[15:0] = count;
    end else if (hit(avs_address, avs_address_hi, `OFS_MODULO)) begin
      next_readdata[15:0] = modulo_value;
    end else if (hit(avs_address, avs_address_hi, `OFS_STATUS)) begin
      next_readdata[`ST_W-1:0] = status;
    end else if (hit(avs_address, avs_address_hi, `OFS_MASK)) begin
      next_readdata[`ST_W-1:0] = mask;
    end else begin
      next_response = 2'h2; // Slave error on unmapped address
    end
  end

  // Bus handshake and read data register
  always @(posedge clock) begin
    if (!rst_n) begin
      busy            <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= 2'h0;
    end else if (access) begin
      busy            <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      busy            <= 1'b1;
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
      avs_response    <= next_response;
    end else begin
      busy            <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
  end

  // Register writes, taken at the edge waitrequest is low
  always @(posedge clock) begin
    if (!rst_n) begin
      counter_clock_select   <= `CLK_OFF;
      halt_after_wrap        <= 1'b0;
      begin_on_trigger_edge  <= 1'b0;
      shared_timebase_select <= 1'b0;
      debug_behaviour_field  <= 2'h0;
      doze_pause_select      <= 1'b0;
      modulo_value           <= `RST_MODULO;
      mask                   <= {`ST_W{1'b0}};
    end else if (access && avs_write) begin
      if (hit(avs_address, avs_address_hi, `OFS_CONTROL) &&
          avs_byteenable[0]) begin
        counter_clock_select <= wdata[`CTL_CLK_HI:`CTL_CLK_LO];
      end else if (hit(avs_address, avs_address_hi, `OFS_CONFIG)) begin
        // Only the documented fields take writes
        if (be_mask[`CFG_HALT_WRAP])
          halt_after_wrap <= wdata[`CFG_HALT_WRAP];
        if (be_mask[`CFG_BEGIN_TRIG])
          begin_on_trigger_edge <= wdata[`CFG_BEGIN_TRIG];
        if (be_mask[`CFG_SHARED])
          shared_timebase_select <= wdata[`CFG_SHARED];
        if (be_mask[`CFG_DBG_LO])
          debug_behaviour_field <= wdata[`CFG_DBG_HI:`CFG_DBG_LO];
        if (be_mask[`CFG_DOZE])
          doze_pause_select <= wdata[`CFG_DOZE];
      end else if (hit(avs_address, avs_address_hi, `OFS_MODULO)) begin
        modulo_value <= (modulo_value & ~be_mask[15:0]) | wdata[15:0];
      end else if (hit(avs_address, avs_address_hi, `OFS_MASK) &&
                   avs_byteenable[0]) begin
        mask <= wdata[`ST_W-1:0];
      end
    end
  end

  // Counter cleared by any write to the count register
  always @(posedge clock) begin
    if (!rst_n)
      cnt_clear <= 1'b0;
    else
      cnt_clear <= access && avs_write &&
                   hit(avs_address, avs_address_hi, `OFS_COUNT);
  end

  // Sticky events; a read clears only the bits it returned, so an event
  // between snapshot and clear is kept; a new event wins over the clear
  always @(posedge clock) begin
    if (!rst_n) begin
      status <= {`ST_W{1'b0}};
    end else begin
      status <= (access && rd_status ?
                 status & ~avs_readdata[`ST_W-1:0] : status) |
                {trig_seen, wrap};
    end
  end

  // Level interrupt from unmasked status
  always @(posedge clock) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

endmodule // timer_counter_config_control

// ### sim/tmr_far_side.sv
// Purpose: Trigger source and shared timebase beside the timer block
// Assumes: Bench pulses fire for one clock to request a trigger
// Notes: Shared count runs 0 to 9 and pulses wrap at 9
`timescale 1ns/10ps
module tmr_far_side (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Request from bench
  input  wire logic        fire,
  // To the block
  output logic             trigger_in,
  output logic [15:0]      shared_count,
  output logic             shared_enable,
  output logic             shared_wrap
);
  logic [2:0] hold;
  // Free running shared timebase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shared_count <= 16'h0;
      shared_enable <= 1'b0;
      shared_wrap <= 1'b0;
    end else begin
      shared_enable <= 1'b1;
      shared_wrap <= shared_count == 16'h9;
      shared_count <= (shared_count == 16'h9) ? 16'h0 : shared_count + 16'h1;
    end
  end
  // Trigger level held four clocks per request
  always_ff @(posedge clock) begin
    if (!rst_n) hold <= 3'h0;
    else if (fire) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
  assign trigger_in = hold != 3'h0;
endmodule // tmr_far_side

// ### sim/timer_counter_config_control_chk.sv
// Purpose: Port checks for the timer control block
// Assumes: Full-lane writes; control and config shadowed from the bus
// Notes: Bound to every instance of the block
`timescale 1ns/10ps
module timer_counter_config_control_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Bus
  input wire logic [3:0]  avs_address,
  input wire logic [4:0]  avs_address_hi,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // Modes and timebase
  input wire logic        debug_mode,
  input wire logic        doze_mode,
  input wire logic [15:0] shared_count,
  input wire logic [15:0] timebase_count,
  input wire logic [15:0] local_count
);
  logic [17:0] cfg;
  logic [1:0]  ctl;
  logic        hit;
  logic        run_ok;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Accepted mapped access and free-run condition
  assign hit = !avs_waitrequest && avs_address_hi == 5'h00;
  assign run_ok = ctl != 2'h0 && cfg[17:16] == 2'h0 && !(doze_mode && cfg[5])
                  && !(debug_mode && cfg[7:6] != 2'h3);
  // Shadow of control and config
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg <= 18'h0;
      ctl <= 2'h0;
    end else if (hit && avs_write && avs_address == 4'h1) begin
      cfg <= avs_writedata[17:0] & 18'h302E0;
    end else if (hit && avs_write && avs_address == 4'h0) begin
      ctl <= avs_writedata[1:0];
    end
  end
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer in one wait");
  property p_unm;
    avs_read && !avs_waitrequest && avs_address_hi != 5'h00
      |-> avs_response == 2'h2 && avs_readdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read answer");
  property p_rsv;
    hit && avs_read && avs_address == 4'h1
      |-> (avs_readdata & 32'hFFFC_FD1F) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_off;
    ctl == 2'h0 && $past(ctl) == 2'h0 && $past(ctl, 2) == 2'h0
      |-> $stable(local_count);
  endproperty
  a_off: assert property (p_off) else $error("count moved off");
  property p_doze;
    (doze_mode && cfg[5]) [*3] |-> $stable(local_count);
  endproperty
  a_doze: assert property (p_doze) else $error("count moved in doze");
  property p_dbg;
    (debug_mode && cfg[7:6] != 2'h3) [*3] |-> $stable(local_count);
  endproperty
  a_dbg: assert property (p_dbg) else $error("count moved in debug");
  property p_run;
    run_ok [*4] |-> local_count != $past(local_count);
  endproperty
  a_run: assert property (p_run) else $error("count stuck");
  property p_gtb;
    cfg[9] && $past(cfg[9]) |-> timebase_count == $past(shared_count);
  endproperty
  a_gtb: assert property (p_gtb) else $error("shared not followed");
  property p_int;
    !cfg[9] && !$past(cfg[9]) |-> timebase_count == local_count;
  endproperty
  a_int: assert property (p_int) else $error("internal not followed");
  c_unm: cover property (avs_read && !avs_waitrequest &&
                         avs_address_hi != 5'h00);
  c_doze: cover property (doze_mode && cfg[5] && ctl != 2'h0);
  c_dbg: cover property (debug_mode && run_ok);
  c_gtb: cover property (cfg[9] && run_ok);
endmodule // timer_counter_config_control_chk

bind timer_counter_config_control timer_counter_config_control_chk
  i_timer_counter_config_control_chk (.clock, .rst_n, .avs_address,
  .avs_address_hi, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
  .avs_waitrequest, .avs_response, .debug_mode, .doze_mode, .shared_count,
  .timebase_count, .local_count);

// ### sim/timer_counter_config_control_tb.sv
// Purpose: Self-checking bench for the timer control block
// Assumes: Modulo set to 3 before counting, so count stays in 0..3
// Notes: Outputs sampled just after each rising edge
`timescale 1ns/10ps
`include "tmr_defines.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module timer_counter_config_control_tb;
  logic clock, rst_n, avs_read, avs_write, debug_mode, doze_mode, fire;
  logic [3:0] avs_address;
  logic [4:0] avs_address_hi;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest, trigger_in, shared_enable, shared_wrap;
  logic timebase_enable, timebase_wrap, irq, sw;
  logic [1:0] avs_response, rsp;
  logic [15:0] shared_count, timebase_count, local_count, c0, s;
  int failures, n_checks;
  timer_counter_config_control i_timer_counter_config_control (.clock,
    .rst_n, .avs_address, .avs_address_hi, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .avs_response, .debug_mode, .doze_mode, .trigger_in, .shared_count,
    .shared_enable, .shared_wrap, .timebase_count, .timebase_enable,
    .timebase_wrap, .local_count, .irq);
  tmr_far_side i_tmr_far_side (.clock, .rst_n, .fire, .trigger_in,
    .shared_count, .shared_enable, .shared_wrap);
  task step(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (avs_waitrequest !== 1'b0);
    // One wait state: request seen, waitrequest low one clock later
    `CHK("wait", 2, t)
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  // Count moves by five, or stands, over five clocks
  task mv(input logic e, input string n);
    step(3);
    c0 = local_count;
    step(5);
    `CHK(n, e ? (c0 + 16'h5) & 16'h3 : c0, local_count)
  endtask
  task pulse;
    fire <= 1'b1;
    step(1);
    fire <= 1'b0;
  endtask
  task t_regs;
    rdc(`OFS_CONFIG, 32'h0, "cfg rst");
    rdc(`OFS_CONTROL, 32'h0, "ctl rst");
    mv(1'b0, "off");
    wr(`OFS_CONFIG, 32'hFFFF_FFFF);
    rdc(`OFS_CONFIG, `CFG_WMASK, "cfg rsv");
    avs_address_hi <= 5'h1;
    wr(`OFS_CONFIG, 32'h0);
    bus(1'b0, `OFS_CONFIG, 32'h0);
    `CHK("unm rsp", 2'h2, rsp)
    `CHK("unm rd", 32'h0, rd)
    avs_address_hi <= 5'h0;
    rdc(`OFS_CONFIG, `CFG_WMASK, "unm wr");
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_MODULO, 32'h3);
  endtask
  task t_run;
    wr(`OFS_CONTROL, 32'h1);
    mv(1'b1, "free");
    `CHK("int en", 1'b1, timebase_enable)
    rdc(`OFS_STATUS, 32'h1, "wrap");
    mv(1'b1, "past wrap");
    wr(`OFS_CONTROL, 32'h0);
  endtask
  task t_trig;
    wr(`OFS_CONFIG, 32'h0003_0000);
    bus(1'b0, `OFS_STATUS, 32'h0);
    wr(`OFS_CONTROL, 32'h1);
    mv(1'b0, "wait trig");
    rdc(`OFS_STATUS, 32'h0, "no wrap");
    wr(`OFS_COUNT, 32'h0);
    rdc(`OFS_COUNT, 32'h0, "cnt clr");
    pulse;
    step(12);
    rdc(`OFS_STATUS, 32'h3, "trig wrap");
    mv(1'b0, "halted");
    rdc(`OFS_COUNT, 32'h0, "halt at 0");
    pulse;
    step(12);
    rdc(`OFS_STATUS, 32'h3, "resume");
    wr(`OFS_CONTROL, 32'h0);
  endtask
  task t_pause;
    wr(`OFS_CONFIG, 32'h0001_0020);
    bus(1'b0, `OFS_STATUS, 32'h0);
    doze_mode <= 1'b1;
    wr(`OFS_CONTROL, 32'h1);
    pulse;
    step(8);
    rdc(`OFS_STATUS, 32'h0, "doze trig");
    doze_mode <= 1'b0;
    mv(1'b0, "still wait");
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_CONFIG, 32'h0);
    debug_mode <= 1'b1;
    wr(`OFS_CONTROL, 32'h1);
    mv(1'b0, "dbg hold");
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_CONFIG, 32'h0000_00C0);
    doze_mode <= 1'b1;
    wr(`OFS_CONTROL, 32'h1);
    mv(1'b1, "dbg run");
    debug_mode <= 1'b0;
    doze_mode <= 1'b0;
    wr(`OFS_CONTROL, 32'h0);
  endtask
  task t_gtb;
    wr(`OFS_CONFIG, 32'h0000_0200);
    bus(1'b0, `OFS_STATUS, 32'h0);
    wr(`OFS_MASK, 32'h1);
    wr(`OFS_CONTROL, 32'h1);
    step(2);
    s = shared_count;
    sw = shared_wrap;
    step(1);
    `CHK("shared", s, timebase_count)
    `CHK("sh wrap", sw, timebase_wrap)
    `CHK("sh en", 1'b1, timebase_enable)
    mv(1'b1, "local");
    `CHK("irq", 1'b1, irq)
    wr(`OFS_CONTROL, 32'h0);
    step(2);
    bus(1'b0, `OFS_STATUS, 32'h0);
    step(2);
    `CHK("irq clr", 1'b0, irq)
    wr(`OFS_CONFIG, 32'h0);
    step(4);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Clock at 125 MHz
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Main sequence
  initial begin
    {rst_n, avs_read, avs_write, debug_mode, doze_mode, fire} = 6'h0;
    avs_address = 4'h0;
    avs_address_hi = 5'h0;
    avs_writedata = 32'h0;
    failures = 0;
    n_checks = 0;
    step(12);
    rst_n <= 1'b1;
    step(1);
    t_regs;
    t_run;
    t_trig;
    t_pause;
    t_gtb;
    stop_test;
  end
  // Watchdog against a hang
  initial begin
    step(5000);
    failures++;
    stop_test;
  end
endmodule // timer_counter_config_control_tb
